/* File: hw/bmdb_core.sv */
// Bit memory operation and debug break execution unit
`timescale 1ns/1ps
// Overview of operation
// (RULE1) Bit clear zeroes the indexed bit of the addressed byte in 3 cycles.
// (RULE2) Bit invert complements the indexed bit and writes back, 3 cycles.
// (RULE3) Bit set forces the indexed bit to one in 3 cycles.
// (RULE4) Bit test loads zero flag with inverted bit; memory untouched.
// (RULE5) One prefix adds a 13-bit zero-extended displacement to base.
// (RULE6) Two prefixes form 26-bit displacement, first prefix high half.
// (RULE7) Bit ops: class 15:13, op1, op2, base 7:4, bit3 zero, index 2:0.
// (RULE8) Break saves pc+2 at word 8 and register zero at word C, 10 cycles.
// (RULE9) Break then fetches handler vector and loads it into the pc.
// (RULE10) Break also enters debug mode.
// (RULE11) Debug mode is left only by the dedicated debug return.
// (RULE12) Clear, set and invert keep flags and do one byte read then one byte write.
module bmdb_core
   import bmdb_pkg::*;
#(
   parameter logic HIGH_VEC = 1'b0
)
(
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire bmdb_issue_t ISSUE_I,
   input wire logic MEM_ACK_I,
   input wire logic [31:0] MEM_RDATA_I,
   input wire logic Z_FLAG_I,
   output bmdb_mreq_t MEM_REQ_O,
   output logic BUSY_O,
   output logic DONE_O,
   output logic ILLEGAL_O,
   output logic Z_WE_O,
   output logic Z_VAL_O,
   output logic PC_WE_O,
   output logic [31:0] PC_VAL_O,
   output logic DEBUG_MODE_O
);
   // Refuse cycle counts the sequencer cannot serve
   if (BIT_CYCLES != 3 || BRK_CYCLES < 4) begin : g_bad_counts
      $error("bmdb_core: unsupported cycle counts");
   end

   bmdb_state_t state_ff, nxt_state;
   bmdb_mreq_t mreq_ff, nxt_mreq;
   logic [1:0] op_ff;
   logic [2:0] idx_ff;
   logic [31:0] addr_ff;
   logic [31:0] ret_pc_ff;
   logic [31:0] gr0_ff;
   logic [3:0] cyc_ff;
   logic busy_ff, done_ff, ill_ff, zwe_ff, zval_ff, pcwe_ff, dbg_ff;
   logic [31:0] pcval_ff;

   wire logic [15:0] code = ISSUE_I.code;
   wire logic idle = (state_ff == BMDB_IDLE);
   wire logic take = idle && ISSUE_I.valid;
   // Instruction decode
   wire logic is_bitop = code[CLASS_HI:CLASS_LO] == CLASS_BITOP &&
      code[OP1_HI:OP1_LO] == OP1_BITOP && !code[ZERO_BIT]; // RULE7
   wire logic is_ext = code[CLASS_HI:CLASS_LO] == CLASS_EXT;
   wire logic is_brk = code == OPC_BRK;
   wire logic is_retd = code == OPC_RETD;
   wire logic bad_fmt = code[CLASS_HI:CLASS_LO] == CLASS_BITOP &&
      code[OP1_HI:OP1_LO] == OP1_BITOP && code[ZERO_BIT]; // RULE7
   wire logic [1:0] dec_op = code[OP2_HI:OP2_LO]; // RULE7
   wire logic [2:0] bit_index_field = code[IDX_HI:IDX_LO]; // RULE7
   wire logic [31:0] eff_addr;
   wire logic [31:0] vec_base = HIGH_VEC ? DBG_VEC_HI : DBG_VEC_LO;
   wire logic [7:0] rd_byte = byte_of(MEM_RDATA_I, addr_ff[1:0]);
   wire logic sel_bit = rd_byte[idx_ff];
   wire logic [7:0] mask = 8'h01 << idx_ff;
   wire logic [7:0] new_byte = modify(rd_byte, mask, op_ff);

   // Byte lane pick from a word bus
   function automatic logic [7:0] byte_of(input logic [31:0] w,
                                          input logic [1:0] lane);
      byte_of = w[{lane, 3'b000} +: 8];
   endfunction

   // Read-modify for clear, set and invert
   function automatic logic [7:0] modify(input logic [7:0] b,
                                         input logic [7:0] m,
                                         input logic [1:0] op);
      unique case (op)
         OP2_BCLR: modify = b & ~m; // RULE1
         OP2_BSET: modify = b | m; // RULE3
         OP2_BNOT: modify = b ^ m; // RULE2
         OP2_BTST: modify = b;
      endcase
   endfunction

   bmdb_ext_acc u_ext (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .ext_valid_i(take && is_ext),
      .ext_imm_i(code[12:0]),
      .consume_i(take && !is_ext),
      .base_i(ISSUE_I.base_val),
      .eff_addr_o(eff_addr) // RULE5 RULE6
   );

   // Next state and memory request
   always_comb begin
      nxt_state = state_ff;
      nxt_mreq = mreq_ff;
      unique case (state_ff)
         BMDB_IDLE: begin
            nxt_mreq = '0;
            if (take && is_bitop) begin
               nxt_state = BMDB_BREAD;
               nxt_mreq = '{1'b1, 1'b0, 1'b1, eff_addr, 32'h0}; // RULE12
            end else if (take && is_brk && !dbg_ff) begin
               nxt_state = BMDB_KSAVE_PC;
               nxt_mreq = '{1'b1, 1'b1, 1'b0, vec_base + DBG_PC_OFS,
                            ISSUE_I.pc + PC_STEP}; // RULE8
            end
         end
         BMDB_BREAD: if (MEM_ACK_I) begin
            // Test writes nothing but still spends the write slot
            if (op_ff == OP2_BTST) begin
               nxt_state = BMDB_BWRITE; // RULE4
               nxt_mreq = '0;
            end else begin
               nxt_state = BMDB_BWRITE;
               nxt_mreq = '{1'b1, 1'b1, 1'b1, addr_ff,
                            {4{new_byte}}}; // RULE12
            end
         end
         BMDB_BWRITE: if (MEM_ACK_I || op_ff == OP2_BTST) begin // RULE4
            nxt_state = BMDB_BDONE;
            nxt_mreq = '0;
         end
         BMDB_BDONE: nxt_state = BMDB_IDLE;
         BMDB_KSAVE_PC: if (MEM_ACK_I) begin
            nxt_state = BMDB_KSAVE_R0;
            nxt_mreq = '{1'b1, 1'b1, 1'b0, vec_base + DBG_R0_OFS,
                         gr0_ff}; // RULE8
         end
         BMDB_KSAVE_R0: if (MEM_ACK_I) begin
            nxt_state = BMDB_KVEC;
            nxt_mreq = '{1'b1, 1'b0, 1'b0, vec_base, 32'h0}; // RULE9
         end
         BMDB_KVEC: if (MEM_ACK_I) begin
            nxt_state = BMDB_KWAIT;
            nxt_mreq = '0;
         end
         BMDB_KWAIT: if (cyc_ff >= BRK_LAST) nxt_state = BMDB_IDLE; // RULE8
      endcase
   end

   // Sequencer registers
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_ff <= BMDB_IDLE;
         mreq_ff <= '0;
         op_ff <= 2'h0;
         idx_ff <= 3'h0;
         addr_ff <= 32'h0;
         ret_pc_ff <= 32'h0;
         gr0_ff <= 32'h0;
         cyc_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         mreq_ff <= nxt_mreq;
         cyc_ff <= idle ? 4'h0 : cyc_ff + 4'h1;
         if (take) begin
            op_ff <= dec_op;
            idx_ff <= bit_index_field;
            addr_ff <= eff_addr;
            ret_pc_ff <= ISSUE_I.pc + PC_STEP;
            gr0_ff <= ISSUE_I.gr0_val;
         end
      end
   end

   // Status outputs, flag and pc updates
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         ill_ff <= 1'b0;
         zwe_ff <= 1'b0;
         zval_ff <= 1'b0;
         pcwe_ff <= 1'b0;
         pcval_ff <= 32'h0;
         dbg_ff <= 1'b0;
      end else begin
         busy_ff <= nxt_state != BMDB_IDLE;
         done_ff <= (state_ff == BMDB_BDONE) ||
            (state_ff == BMDB_KWAIT && nxt_state == BMDB_IDLE) ||
            (take && is_retd && dbg_ff);
         ill_ff <= take && (bad_fmt || (is_brk && dbg_ff) ||
            (is_retd && !dbg_ff));
         // Zero flag only written by the test op
         zwe_ff <= state_ff == BMDB_BREAD && MEM_ACK_I &&
            op_ff == OP2_BTST; // RULE4 RULE12
         zval_ff <= (state_ff == BMDB_BREAD && MEM_ACK_I) ? !sel_bit :
            Z_FLAG_I; // RULE4
         pcwe_ff <= state_ff == BMDB_KVEC && MEM_ACK_I; // RULE9
         if (state_ff == BMDB_KVEC && MEM_ACK_I)
            pcval_ff <= MEM_RDATA_I; // RULE9
         else if (take && is_retd && dbg_ff)
            pcval_ff <= ret_pc_ff;
         if (state_ff == BMDB_KVEC && MEM_ACK_I)
            dbg_ff <= 1'b1; // RULE10
         else if (take && is_retd)
            dbg_ff <= 1'b0; // RULE11
      end
   end

   assign MEM_REQ_O = mreq_ff;
   assign BUSY_O = busy_ff;
   assign DONE_O = done_ff;
   assign ILLEGAL_O = ill_ff;
   assign Z_WE_O = zwe_ff;
   assign Z_VAL_O = zval_ff;
   assign PC_WE_O = pcwe_ff;
   assign PC_VAL_O = pcval_ff;
   assign DEBUG_MODE_O = dbg_ff;
endmodule

/* File: hw/bmdb_ext_acc.sv */
// Extension prefix accumulator and effective address adder
`timescale 1ns/1ps
module bmdb_ext_acc
   import bmdb_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ext_valid_i,
   input wire logic [12:0] ext_imm_i,
   input wire logic consume_i,
   input wire logic [31:0] base_i,
   output logic [31:0] eff_addr_o
);
   logic [1:0] ext_cnt_ff;
   logic [25:0] long_displacement_ff;
   logic [1:0] nxt_ext_cnt;
   logic [25:0] nxt_long_displacement;
   wire logic [31:0] disp_ext;

   // Shift prefixes in; first gives bits 25:13, second 12:0
   assign nxt_long_displacement = consume_i ? 26'h0 :
      ext_valid_i ? {long_displacement_ff[12:0], ext_imm_i} :
      long_displacement_ff; // RULE6
   assign nxt_ext_cnt = consume_i ? 2'h0 :
      (ext_valid_i && ext_cnt_ff != 2'h2) ? ext_cnt_ff + 2'h1 : ext_cnt_ff;
   // Zero-extended displacement; none when no prefix seen
   assign disp_ext = (ext_cnt_ff == 2'h0) ? 32'h0 :
      {6'h00, long_displacement_ff}; // RULE5
   assign eff_addr_o = base_i + disp_ext; // RULE5 RULE6

   // Prefix state
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ext_cnt_ff <= 2'h0;
         long_displacement_ff <= 26'h0;
      end else begin
         ext_cnt_ff <= nxt_ext_cnt;
         long_displacement_ff <= nxt_long_displacement;
      end
   end
endmodule

/* File: hw/bmdb_pkg.sv */
// Package: constants and types for bit memory ops and debug break unit
package bmdb_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   // Instruction field positions
   localparam int CLASS_HI = 15;
   localparam int CLASS_LO = 13;
   localparam int OP1_HI = 12;
   localparam int OP1_LO = 10;
   localparam int OP2_HI = 9;
   localparam int OP2_LO = 8;
   localparam int BASE_HI = 7;
   localparam int BASE_LO = 4;
   localparam int ZERO_BIT = 3;
   localparam int IDX_HI = 2;
   localparam int IDX_LO = 0;
   localparam int EXT_W = 13;
   // Opcode values
   localparam logic [2:0] CLASS_BITOP = 3'h5;
   localparam logic [2:0] OP1_BITOP = 3'h4;
   localparam logic [1:0] OP2_BTST = 2'h2;
   localparam logic [1:0] OP2_BCLR = 2'h1;
   localparam logic [1:0] OP2_BSET = 2'h0;
   localparam logic [1:0] OP2_BNOT = 2'h3;
   localparam logic [15:0] OPC_BRK = 16'h0400;
   localparam logic [15:0] OPC_RETD = 16'h0440;
   localparam logic [2:0] CLASS_EXT = 3'h6;
   // Debug words, low and high vector bank
   localparam logic [31:0] DBG_VEC_LO = 32'h0000_0000;
   localparam logic [31:0] DBG_VEC_HI = 32'h0006_0000;
   localparam logic [31:0] DBG_PC_OFS = 32'h0000_0008;
   localparam logic [31:0] DBG_R0_OFS = 32'h0000_000C;
   localparam logic [31:0] PC_STEP = 32'h0000_0002;
   // Cycle counts
   localparam int BIT_CYCLES = 3;
   localparam int BRK_CYCLES = 10;
   localparam logic [3:0] BRK_LAST = 4'(BRK_CYCLES - 1);

   typedef enum logic [2:0] {
      BMDB_IDLE = 3'b000,
      BMDB_BREAD = 3'b001,
      BMDB_BWRITE = 3'b010,
      BMDB_BDONE = 3'b011,
      BMDB_KSAVE_PC = 3'b100,
      BMDB_KSAVE_R0 = 3'b101,
      BMDB_KVEC = 3'b110,
      BMDB_KWAIT = 3'b111
   } bmdb_state_t;

   // Memory request carrier
   typedef struct packed {
      logic req;
      logic we;
      logic byte_sz;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bmdb_mreq_t;

   // Issued instruction carrier
   typedef struct packed {
      logic valid;
      logic [15:0] code;
      logic [31:0] pc;
      logic [31:0] base_val;
      logic [31:0] gr0_val;
   } bmdb_issue_t;
endpackage

/* File: sim/bmdb_core_props.sv */
// Checker for the bit operation and debug break unit
`timescale 1ns/1ps
module bmdb_core_props
   import bmdb_pkg::*;
#(
   parameter logic HIGH_VEC = 1'b0
)
(
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire bmdb_issue_t ISSUE_I,
   input wire logic MEM_ACK_I,
   input wire logic [31:0] MEM_RDATA_I,
   input wire logic Z_FLAG_I,
   input wire bmdb_mreq_t MEM_REQ_O,
   input wire logic BUSY_O,
   input wire logic DONE_O,
   input wire logic ILLEGAL_O,
   input wire logic Z_WE_O,
   input wire logic Z_VAL_O,
   input wire logic PC_WE_O,
   input wire logic [31:0] PC_VAL_O,
   input wire logic DEBUG_MODE_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   // Accepted requests by kind
   wire take = ISSUE_I.valid && !BUSY_O;
   wire bitop = take && ISSUE_I.code[15:10] == {CLASS_BITOP, OP1_BITOP};
   wire brk = take && ISSUE_I.code == OPC_BRK && !DEBUG_MODE_O;
   wire [31:0] vec = HIGH_VEC ? DBG_VEC_HI : DBG_VEC_LO;
   wire wr = MEM_REQ_O.req && MEM_REQ_O.we;
   a_bit_read: assert property (bitop && !ISSUE_I.code[3] |=>
      MEM_REQ_O.req && !MEM_REQ_O.we && MEM_REQ_O.byte_sz)
      else $error("bit op did not start with a byte read");
   a_bad_format: assert property (bitop && ISSUE_I.code[3] |->
      ##[1:2] ILLEGAL_O) else $error("bad bit op format not flagged");
   a_req_hold: assert property (MEM_REQ_O.req && !MEM_ACK_I |=>
      MEM_REQ_O.req && $stable(MEM_REQ_O))
      else $error("request changed before ack");
   a_byte_lanes: assert property (wr && MEM_REQ_O.byte_sz |->
      MEM_REQ_O.wdata == {4{MEM_REQ_O.wdata[7:0]}})
      else $error("byte write not on all lanes");
   a_test_ro: assert property (bitop && ISSUE_I.code[9:8] == OP2_BTST
      |=> (!wr) [*4]) else $error("bit test wrote memory");
   a_brk_time: assert property (brk |=> (!DONE_O) [*8] ##1 !DONE_O)
      else $error("break finished too early");
   a_brk_vector: assert property (brk |-> ##[3:40]
      MEM_REQ_O.req && !MEM_REQ_O.we && MEM_REQ_O.addr == vec)
      else $error("break did not read the vector");
   a_dbg_stays: assert property (DEBUG_MODE_O && take &&
      ISSUE_I.code != OPC_RETD |=> DEBUG_MODE_O)
      else $error("debug mode left without debug return");
   a_dbg_entry: assert property ($rose(DEBUG_MODE_O) |-> $past(BUSY_O))
      else $error("debug mode entered outside an operation");
endmodule
bind bmdb_core bmdb_core_props #(.HIGH_VEC(HIGH_VEC)) u_props (
   .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .ISSUE_I(ISSUE_I),
   .MEM_ACK_I(MEM_ACK_I), .MEM_RDATA_I(MEM_RDATA_I), .Z_FLAG_I(Z_FLAG_I),
   .MEM_REQ_O(MEM_REQ_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
   .ILLEGAL_O(ILLEGAL_O), .Z_WE_O(Z_WE_O), .Z_VAL_O(Z_VAL_O),
   .PC_WE_O(PC_WE_O), .PC_VAL_O(PC_VAL_O), .DEBUG_MODE_O(DEBUG_MODE_O));

/* File: sim/bmdb_mem_model.sv */
// Memory model answering byte and word requests of the unit
`timescale 1ns/1ps
module bmdb_mem_model
   import bmdb_pkg::*;
(
   input wire logic clk_i,
   input wire bmdb_mreq_t req_i,
   input wire logic [3:0] delay_i,
   output logic ack_o,
   output logic [31:0] rdata_o
);
   logic [7:0] mem [0:65535];
   logic [3:0] wait_ff = 4'h0;
   logic [31:0] last_ff = 32'h0000_0000;
   wire [15:0] a = {req_i.addr[15:2], 2'b00};
   wire [31:0] word = {mem[a + 3], mem[a + 2], mem[a + 1], mem[a]};
   // Ack after the chosen number of wait cycles
   assign ack_o = req_i.req && wait_ff == delay_i;
   // Released data bus shows inverse of last word
   assign rdata_o = ack_o ? word : ~last_ff;
   // Write lanes, one byte only on byte requests
   always @(posedge clk_i) begin
      wait_ff <= (ack_o || !req_i.req) ? 4'h0 : wait_ff + 4'h1;
      if (ack_o) last_ff <= word;
      for (int k = 0; k < 4; k++) begin
         if (ack_o && req_i.we && (!req_i.byte_sz ||
             a + k == req_i.addr[15:0])) mem[a + k] <= req_i.wdata[8*k+:8];
      end
   end
endmodule

/* File: sim/testbench.sv */
// Bench for the bit operation and debug break unit
`timescale 1ns/1ps
module testbench;
   import bmdb_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   bmdb_issue_t iss = '0;
   logic [3:0] dly = 4'h0;
   bmdb_mreq_t req;
   logic ack, done, busy, ill, zwe, zval, pcwe, dbg, zv, si;
   logic [31:0] rdata, pcv, pv;
   int fail_count = 0;
   int samples_checked = 0;
   int n, zn, zc;
   always #50 clk = ~clk;
   bmdb_core uut (.CLK_I(clk), .RESET_N_I(rst_n), .ISSUE_I(iss),
      .MEM_ACK_I(ack), .MEM_RDATA_I(rdata), .Z_FLAG_I(1'b0),
      .MEM_REQ_O(req), .BUSY_O(busy), .DONE_O(done), .ILLEGAL_O(ill),
      .Z_WE_O(zwe), .Z_VAL_O(zval), .PC_WE_O(pcwe), .PC_VAL_O(pcv),
      .DEBUG_MODE_O(dbg));
   bmdb_mem_model mem (.clk_i(clk), .req_i(req), .delay_i(dly),
      .ack_o(ack), .rdata_o(rdata));
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [31:0] get32(int a);
      return {mem.mem[a + 3], mem.mem[a + 2], mem.mem[a + 1], mem.mem[a]};
   endfunction
   task automatic send(logic [15:0] c, logic [31:0] b);
      @(negedge clk);
      iss = '{1'b1, c, 32'h0000_1000, b, 32'h1234_5678};
   endtask
   // Drop valid, count cycles to done, note pulses
   task automatic finish_op();
      @(negedge clk);
      iss.valid = 1'b0;
      n = 0;
      zc = 0;
      // Illegal pulse already stands one edge after issue
      si = (ill === 1'b1);
      while (done !== 1'b1 && si !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
         if (zwe === 1'b1) zn = n;
         if (zwe === 1'b1) zc++;
         if (zwe === 1'b1) zv = zval;
         if (pcwe === 1'b1) pv = pcv;
         if (ill === 1'b1) si = 1'b1;
      end
      repeat (2) @(negedge clk);
   endtask
   task automatic t_modify();
      logic [1:0] op [3] = '{OP2_BCLR, OP2_BSET, OP2_BNOT};
      logic [31:0] b [3] = '{32'h0000_0101, 32'h0000_0040, 32'h0000_0100};
      int ea [3] = '{32'h0101, 32'h203F, 32'h2105};
      logic [2:0] ix [3] = '{3'h0, 3'h3, 3'h7};
      logic [7:0] e;
      for (int k = 0; k < 3; k++) begin
         mem.mem[ea[k]] = 8'hA5;
         mem.mem[ea[k] + 1] = 8'h3C;
         e = 8'hA5;
         e[ix[k]] = (k == 0) ? 1'b0 : (k == 1) ? 1'b1 : ~e[ix[k]];
         if (k == 1) send({CLASS_EXT, 13'h1FFF}, 32'h0);
         if (k == 2) send({CLASS_EXT, 13'h0001}, 32'h0);
         if (k == 2) send({CLASS_EXT, 13'h0005}, 32'h0);
         send({CLASS_BITOP, OP1_BITOP, op[k], 4'h3, 1'b0, ix[k]}, b[k]);
         finish_op();
         check("byte", {24'h0, e}, {24'h0, mem.mem[ea[k]]});
         check("next byte", 32'h3C, {24'h0, mem.mem[ea[k] + 1]});
         check("cycles", 3, n);
         check("flag writes", 0, zc);
      end
      $display("t_modify done");
   endtask
   task automatic t_test();
      mem.mem[16'h0101] = 8'h04;
      for (int i = 0; i < 2; i++) begin
         send({CLASS_BITOP, OP1_BITOP, OP2_BTST, 5'h00, 3'(i * 2)}, 32'h101);
         finish_op();
         check("zero flag", {31'h0, i == 0}, {31'h0, zv});
         check("flag cycle", 1, zn);
         check("test cycles", 3, n);
         check("flag writes", 1, zc);
         check("byte", 32'h04, {24'h0, mem.mem[16'h0101]});
      end
      $display("t_test done");
   endtask
   task automatic t_break();
      for (int k = 0; k < 4; k++) mem.mem[k] = 8'(32'h0000_4000 >> 8 * k);
      send(OPC_BRK, 32'h0);
      finish_op();
      check("break cycles", 10, n);
      check("saved pc", 32'h0000_1002, get32(8));
      check("saved reg", 32'h1234_5678, get32(12));
      check("handler pc", 32'h0000_4000, pv);
      check("debug mode", 1, dbg);
      dly = 4'h2;
      send({CLASS_BITOP, OP1_BITOP, OP2_BSET, 5'h00, 3'h1}, 32'h101);
      finish_op();
      check("slow byte", 32'h06, {24'h0, mem.mem[16'h0101]});
      check("still debug", 1, dbg);
      dly = 4'h0;
      send(OPC_BRK, 32'h0);
      finish_op();
      check("nested break", 1, si);
      send(OPC_RETD, 32'h0);
      finish_op();
      check("debug left", 0, dbg);
      $display("t_break done");
   endtask
   task automatic t_format();
      send({CLASS_BITOP, OP1_BITOP, OP2_BSET, 5'h01, 3'h0}, 32'h101);
      finish_op();
      check("format flag", 1, si);
      check("byte kept", 32'h06, {24'h0, mem.mem[16'h0101]});
      $display("t_format done");
   endtask
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence after reset
   initial begin
      repeat (20) @(negedge clk);
      check("busy in reset", 0, busy);
      rst_n = 1'b1;
      t_modify();
      t_test();
      t_break();
      t_format();
      end_of_test();
   end
   // Watchdog well past the expected run
   initial begin
      #300000;
      fail_count++;
      end_of_test();
   end
endmodule
